//--- src/standalone_pkg.sv
// Constants and types shared by the standalone packet decoder.
//Function
//- Mode pin sampled once after power-up; high means standalone, else processor.
//- In standalone mode configuration holds its reset default until rewritten.
//- Configuration port stays writable in standalone mode without leaving it.
//- Band pins pick band; channel pins pick channel; low two set address.
//- Extra strap input enables duty-cycled low-power receive in standalone.
//- Lowest channel pin high raises strength threshold from -103 to -97 dBm.
//- Packet is preamble, sync word, address byte, then control bytes.
//- Per output code: 00 hold, 01 low, 10 toggle, 11 high 100 ms.
//- Control byte accepted only when its inverted copy matches.
//- Sync word is the fixed value 2DD4h.
package standalone_pkg;

	// ********************************************************
	// Packet format
	// ********************************************************
	localparam logic [15:0] SYNC_WORD   = 16'h2DD4;
	localparam int          SYNC_BITS   = 16;
	localparam int          BYTE_BITS   = 8;
	localparam logic [2:0]  BIT_LAST    = 3'h7;

	// Expected address byte per low channel-pick pair.
	localparam logic [7:0]  ADDR_CH0    = 8'hD4;
	localparam logic [7:0]  ADDR_CH1    = 8'hD2;
	localparam logic [7:0]  ADDR_CH2    = 8'hB4;
	localparam logic [7:0]  ADDR_CH3    = 8'hB2;

	// ********************************************************
	// Output command codes and field layout
	// ********************************************************
	localparam logic [1:0]  CODE_HOLD   = 2'h0;
	localparam logic [1:0]  CODE_LOW    = 2'h1;
	localparam logic [1:0]  CODE_TOGGLE = 2'h2;
	localparam logic [1:0]  CODE_PULSE  = 2'h3;
	localparam int          OUT_COUNT   = 4;
	localparam int          FIELD_BITS  = 2;

	// ********************************************************
	// Timing and reset values
	// ********************************************************
	localparam int          CLK_MHZ      = 100;
	localparam int          PULSE_MS     = 100;
	localparam int          PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;
	localparam int          PULSE_W      = 24;
	localparam logic [15:0] CFG_DEFAULT  = 16'h0000;
	localparam logic [1:0]  BAND_RESET   = 2'h0;
	localparam logic [3:0]  CHAN_RESET   = 4'h0;

	typedef enum logic [2:0] {
		ST_HUNT = 3'b000,
		ST_ADDR = 3'b001,
		ST_DATA = 3'b011,
		ST_INV  = 3'b010,
		ST_COPY = 3'b110
	} parse_state_type;

endpackage : standalone_pkg

//--- src/remote_output_driver.sv
// One remote output line with its timed high pulse.
`timescale 1ns/10ps
module remote_output_driver
	import standalone_pkg::*;
#(
	parameter int PULSE_LEN = PULSE_CYCLES
) (
	input  wire logic       clk,       // System clock.
	input  wire logic       rst_n,     // Asynchronous reset, active low.
	input  wire logic       cmdValid,  // Accepted command, one cycle.
	input  wire logic [1:0] cmdCode,   // Two-bit code for this line.
	output logic            level_ff   // Output line level.
);

	logic [PULSE_W-1:0]  timer_ff;
	logic [PULSE_W-1:0]  nxt_timer;
	logic                nxt_level;

	always_comb begin
		nxt_level = level_ff;
		nxt_timer = timer_ff;
		if (timer_ff != '0) begin
			nxt_timer = timer_ff - 1'b1;
			if (timer_ff == PULSE_W'(1))
				nxt_level = 1'b0;
		end
		if (cmdValid) begin
			case (cmdCode)
				CODE_LOW: begin
					nxt_level = 1'b0;
					nxt_timer = '0;
				end
				CODE_TOGGLE: begin
					nxt_level = ~level_ff;
					nxt_timer = '0;
				end
				CODE_PULSE: begin
					nxt_level = 1'b1;
					nxt_timer = PULSE_W'(PULSE_LEN);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_ff <= 1'b0;
			timer_ff <= '0;
		end else begin
			level_ff <= nxt_level;
			timer_ff <= nxt_timer;
		end
	end

endmodule : remote_output_driver

//--- src/standalone_packet_output_decoder.sv
// Standalone-mode strap capture, packet parser and output control.
`timescale 1ns/10ps
module standalone_packet_output_decoder
	import standalone_pkg::*;
#(
	parameter int PULSE_LEN = PULSE_CYCLES
) (
	input  wire logic        clk,                  // System clock, 100 MHz.
	input  wire logic        rst_n,                // Power-on reset, low.
	input  wire logic        operating_choice_pin, // Mode strap, high=alone.
	input  wire logic        lowPowerStrap,        // Duty-cycle strap.
	input  wire logic        band_pick_bit0,       // Band select bit 0.
	input  wire logic        band_pick_bit1,       // Band select bit 1.
	input  wire logic        channel_pick_bit0,    // Channel select bit 0.
	input  wire logic        channel_pick_bit1,    // Channel select bit 1.
	input  wire logic        channel_pick_bit2,    // Channel select bit 2.
	input  wire logic        channel_pick_bit3,    // Channel select bit 3.
	input  wire logic        rxBit,                // Demodulated data bit.
	input  wire logic        rxBitStrobe,          // rxBit valid, one cycle.
	input  wire logic        cfgWrite,             // Config write strobe.
	input  wire logic [15:0] cfgWord,              // Config write data.
	output logic             standaloneMode_ff,    // Standalone selected.
	output logic             modeSampled_ff,       // Mode strap captured.
	output logic [1:0]       bandSelect_ff,        // Band in use.
	output logic [3:0]       channelSelect_ff,     // Channel in use.
	output logic [7:0]       expectedAddr_ff,      // Address to match.
	output logic             strength_threshold_flag, // High threshold.
	output logic             lowPowerEnable_ff,    // Duty-cycled receive.
	output logic [15:0]      cfgValue_ff,          // Config register.
	output logic             packetAccepted_ff,    // Good packet, pulse.
	output logic             packetDiscarded_ff,   // Bad packet, pulse.
	output logic             remote_output_1,      // Output line 1.
	output logic             remote_output_2,      // Output line 2.
	output logic             remote_output_3,      // Output line 3.
	output logic             remote_output_4       // Output line 4.
);

	// ********************************************************
	// Mode strap and configuration
	// ********************************************************
	logic        nxt_sampled;
	logic        nxt_standalone;
	logic [1:0]  nxt_band;
	logic [3:0]  nxt_channel;
	logic [7:0]  nxt_addr;
	logic        nxt_threshold;
	logic        nxt_lowPower;
	logic [15:0] nxt_cfg;
	logic        threshold_ff;

	always_comb begin
		nxt_sampled    = 1'b1;
		nxt_standalone = standaloneMode_ff;
		if (!modeSampled_ff)
			nxt_standalone = operating_choice_pin;
		nxt_band      = bandSelect_ff;
		nxt_channel   = channelSelect_ff;
		nxt_addr      = expectedAddr_ff;
		nxt_threshold = 1'b0;
		nxt_lowPower  = 1'b0;
		if (standaloneMode_ff) begin
			nxt_band    = {band_pick_bit1, band_pick_bit0};
			nxt_channel = {channel_pick_bit3, channel_pick_bit2,
			               channel_pick_bit1, channel_pick_bit0};
			case ({channel_pick_bit1, channel_pick_bit0})
				2'h0:    nxt_addr = ADDR_CH0;
				2'h1:    nxt_addr = ADDR_CH1;
				2'h2:    nxt_addr = ADDR_CH2;
				default: nxt_addr = ADDR_CH3;
			endcase
			nxt_threshold = channel_pick_bit0;
			nxt_lowPower  = lowPowerStrap;
		end
		// The port keeps working whatever the mode; it never
		// touches the latched mode bit.
		nxt_cfg = cfgValue_ff;
		if (cfgWrite)
			nxt_cfg = cfgWord;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeSampled_ff    <= 1'b0;
			standaloneMode_ff <= 1'b0;
			bandSelect_ff     <= BAND_RESET;
			channelSelect_ff  <= CHAN_RESET;
			expectedAddr_ff   <= ADDR_CH0;
			threshold_ff      <= 1'b0;
			lowPowerEnable_ff <= 1'b0;
			cfgValue_ff       <= CFG_DEFAULT;
		end else begin
			modeSampled_ff    <= nxt_sampled;
			standaloneMode_ff <= nxt_standalone;
			bandSelect_ff     <= nxt_band;
			channelSelect_ff  <= nxt_channel;
			expectedAddr_ff   <= nxt_addr;
			threshold_ff      <= nxt_threshold;
			lowPowerEnable_ff <= nxt_lowPower;
			cfgValue_ff       <= nxt_cfg;
		end
	end

	assign strength_threshold_flag = threshold_ff;

	// ********************************************************
	// Packet parser
	// ********************************************************
	parse_state_type state_ff;
	parse_state_type nxt_state;
	logic [15:0]     syncShift_ff;
	logic [15:0]     nxt_syncShift;
	logic [7:0]      byteShift_ff;
	logic [7:0]      nxt_byteShift;
	logic [2:0]      bitCount_ff;
	logic [2:0]      nxt_bitCount;
	logic [7:0]      dataByte_ff;
	logic [7:0]      nxt_dataByte;
	logic [7:0]      invByte_ff;
	logic [7:0]      nxt_invByte;
	logic [7:0]      cmdByte_ff;
	logic [7:0]      nxt_cmdByte;
	logic            nxt_accepted;
	logic            nxt_discarded;
	logic [7:0]      fullByte;
	logic            byteDone;

	always_comb begin
		nxt_state     = state_ff;
		nxt_syncShift = syncShift_ff;
		nxt_byteShift = byteShift_ff;
		nxt_bitCount  = bitCount_ff;
		nxt_dataByte  = dataByte_ff;
		nxt_invByte   = invByte_ff;
		nxt_cmdByte   = cmdByte_ff;
		nxt_accepted  = 1'b0;
		nxt_discarded = 1'b0;
		fullByte      = {byteShift_ff[6:0], rxBit};
		byteDone      = rxBitStrobe && (bitCount_ff == BIT_LAST);
		if (!standaloneMode_ff) begin
			nxt_state = ST_HUNT;
		end else if (rxBitStrobe) begin
			nxt_byteShift = fullByte;
			nxt_bitCount  = bitCount_ff + 1'b1;
			case (state_ff)
				ST_HUNT: begin
					// Preamble bits simply shift through the window.
					nxt_syncShift = {syncShift_ff[14:0], rxBit};
					nxt_bitCount  = '0;
					if ({syncShift_ff[14:0], rxBit} == SYNC_WORD) begin
						nxt_state     = ST_ADDR;
						nxt_syncShift = '0;
					end
				end
				ST_ADDR: begin
					if (byteDone) begin
						if (fullByte == expectedAddr_ff) begin
							nxt_state = ST_DATA;
						end else begin
							nxt_state     = ST_HUNT;
							nxt_discarded = 1'b1;
						end
					end
				end
				ST_DATA: begin
					if (byteDone) begin
						nxt_dataByte = fullByte;
						nxt_state    = ST_INV;
					end
				end
				ST_INV: begin
					if (byteDone) begin
						nxt_invByte = fullByte;
						nxt_state   = ST_COPY;
					end
				end
				ST_COPY: begin
					if (byteDone) begin
						nxt_state = ST_HUNT;
						if ((invByte_ff == ~dataByte_ff) &&
						    (fullByte == dataByte_ff)) begin
							nxt_cmdByte  = dataByte_ff;
							nxt_accepted = 1'b1;
						end else begin
							nxt_discarded = 1'b1;
						end
					end
				end
				default: begin
					nxt_state = ST_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff           <= ST_HUNT;
			syncShift_ff       <= '0;
			byteShift_ff       <= '0;
			bitCount_ff        <= '0;
			dataByte_ff        <= '0;
			invByte_ff         <= '0;
			cmdByte_ff         <= '0;
			packetAccepted_ff  <= 1'b0;
			packetDiscarded_ff <= 1'b0;
		end else begin
			state_ff           <= nxt_state;
			syncShift_ff       <= nxt_syncShift;
			byteShift_ff       <= nxt_byteShift;
			bitCount_ff        <= nxt_bitCount;
			dataByte_ff        <= nxt_dataByte;
			invByte_ff         <= nxt_invByte;
			cmdByte_ff         <= nxt_cmdByte;
			packetAccepted_ff  <= nxt_accepted;
			packetDiscarded_ff <= nxt_discarded;
		end
	end

	// ********************************************************
	// Output lines
	// ********************************************************
	logic [OUT_COUNT-1:0] lineLevel;

	for (genvar i = 0; i < OUT_COUNT; i++) begin : gLine
		remote_output_driver #(
			.PULSE_LEN (PULSE_LEN)
		) uDriver (
			.clk      (clk),
			.rst_n    (rst_n),
			.cmdValid (packetAccepted_ff),
			.cmdCode  (cmdByte_ff[FIELD_BITS*i +: FIELD_BITS]),
			.level_ff (lineLevel[i])
		);
	end

	assign remote_output_1 = lineLevel[0];
	assign remote_output_2 = lineLevel[1];
	assign remote_output_3 = lineLevel[2];
	assign remote_output_4 = lineLevel[3];

endmodule : standalone_packet_output_decoder

//--- tb/remote_transmitter_model.sv
// Remote transmitter model that sends standalone command packets.
`timescale 1ns/10ps
module remote_transmitter_model
	import standalone_pkg::*;
(
	input  wire logic clk,         // Bit clock.
	output logic      rxBit,       // Serial bit.
	output logic      rxBitStrobe  // Bit valid.
);
	initial begin
		rxBit = 1'b0;
		rxBitStrobe = 1'b0;
	end

	task automatic sendByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(negedge clk);
			rxBit = b[i];
			rxBitStrobe = 1'b1;
		end
	endtask : sendByte

	// The caller picks the inverse and copy bytes, so a bad one is deliberate.
	task automatic sendPacket(input logic [7:0] a, d, n, c);
		sendByte(8'hAA);
		sendByte(8'hAA);
		sendByte(SYNC_WORD[15:8]);
		sendByte(SYNC_WORD[7:0]);
		sendByte(a);
		sendByte(d);
		sendByte(n);
		sendByte(c);
		@(negedge clk);
		rxBitStrobe = 1'b0;
		rxBit = ~rxBit;
	endtask : sendPacket
endmodule : remote_transmitter_model

//--- tb/standalone_packet_output_decoder_checker.sv
// Port-level assertions for the standalone packet decoder.
`timescale 1ns/10ps
module standalone_packet_output_decoder_checker
	import standalone_pkg::*;
#(
	parameter int PULSE_LEN = 20
) (
	input wire logic        clk,                     // Clock.
	input wire logic        rst_n,                   // Reset.
	input wire logic        operating_choice_pin,    // Mode strap.
	input wire logic        lowPowerStrap,           // Duty strap.
	input wire logic        band_pick_bit0,          // Band 0.
	input wire logic        band_pick_bit1,          // Band 1.
	input wire logic        channel_pick_bit0,       // Channel 0.
	input wire logic        channel_pick_bit1,       // Channel 1.
	input wire logic        cfgWrite,                // Write strobe.
	input wire logic [15:0] cfgWord,                 // Write data.
	input wire logic        standaloneMode_ff,       // Mode.
	input wire logic        modeSampled_ff,          // Mode taken.
	input wire logic [1:0]  bandSelect_ff,           // Band.
	input wire logic [7:0]  expectedAddr_ff,         // Address.
	input wire logic        strength_threshold_flag, // Threshold.
	input wire logic        lowPowerEnable_ff,       // Duty cycle.
	input wire logic [15:0] cfgValue_ff,             // Config.
	input wire logic        packetAccepted_ff,       // Accept.
	input wire logic        packetDiscarded_ff,      // Discard.
	input wire logic        remote_output_1,         // Line 1.
	input wire logic        remote_output_2,         // Line 2.
	input wire logic        remote_output_3,         // Line 3.
	input wire logic        remote_output_4          // Line 4.
);
	localparam logic [7:0] ADDRS [4] = '{ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_CH3};
	logic [3:0] lines;
	assign lines = {remote_output_4, remote_output_3, remote_output_2,
		remote_output_1};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_mode_capture: assert property ($rose(modeSampled_ff) |->
		standaloneMode_ff == $past(operating_choice_pin))
		else $error("Mode strap not captured.");
	a_mode_held: assert property (modeSampled_ff |=>
		$stable(standaloneMode_ff)) else $error("Mode changed.");
	a_addr_follow: assert property (standaloneMode_ff |=>
		expectedAddr_ff == ADDRS[$past({channel_pick_bit1, channel_pick_bit0})])
		else $error("Address does not follow channel.");
	a_band_follow: assert property (standaloneMode_ff |=>
		bandSelect_ff == $past({band_pick_bit1, band_pick_bit0}))
		else $error("Band does not follow straps.");
	a_flag_follow: assert property (standaloneMode_ff |=>
		strength_threshold_flag == $past(channel_pick_bit0))
		else $error("Threshold flag wrong.");
	a_duty_follow: assert property (standaloneMode_ff |=>
		lowPowerEnable_ff == $past(lowPowerStrap)) else $error("Duty wrong.");
	a_proc_quiet: assert property (
		modeSampled_ff && !standaloneMode_ff |->
		!strength_threshold_flag && !lowPowerEnable_ff && !packetAccepted_ff)
		else $error("Processor mode not quiet.");
	a_cfg_write: assert property (cfgWrite |=>
		cfgValue_ff == $past(cfgWord)) else $error("Config write lost.");
	a_cfg_keep: assert property (!cfgWrite |=> $stable(cfgValue_ff))
		else $error("Config changed unasked.");
	a_rise_cause: assert property (|(lines & ~$past(lines)) |->
		$past(packetAccepted_ff)) else $error("Line rose without packet.");
	a_accept_gap: assert property (packetAccepted_ff |=>
		!packetAccepted_ff [*8]) else $error("Accept pulses too close.");
	a_discard_gap: assert property (packetDiscarded_ff |=>
		!packetDiscarded_ff [*8]) else $error("Discard pulses too close.");

	c_accept: cover property (packetAccepted_ff);
	c_discard: cover property (packetDiscarded_ff);
	c_pulse: cover property ($fell(remote_output_1));
endmodule : standalone_packet_output_decoder_checker

bind standalone_packet_output_decoder standalone_packet_output_decoder_checker
	#(.PULSE_LEN(PULSE_LEN)) chk (.*);

//--- tb/standalone_packet_output_decoder_bench.sv
// Self-checking bench for the standalone packet decoder.
`timescale 1ns/10ps
module standalone_packet_output_decoder_bench;
	import standalone_pkg::*;
	localparam int P = 20;
	localparam logic [7:0] ADDRS [4] = '{ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_CH3};
	localparam logic [31:0] PKTS [7] = '{32'hD4AA55AA, 32'hD449B649,
		32'hD403FC03, 32'hD40AF00A, 32'hD40AF50B, 32'hD2AA55AA, 32'hD4C03FC0};
	logic clk, rst_n, operating_choice_pin, lowPowerStrap, cfgWrite;
	logic band_pick_bit0, band_pick_bit1, rxBit, rxBitStrobe;
	logic channel_pick_bit0, channel_pick_bit1, channel_pick_bit2;
	logic channel_pick_bit3, standaloneMode_ff, modeSampled_ff;
	logic strength_threshold_flag, lowPowerEnable_ff, packetAccepted_ff;
	logic packetDiscarded_ff, remote_output_1, remote_output_2;
	logic remote_output_3, remote_output_4, good;
	logic [1:0]  bandSelect_ff, code;
	logic [3:0]  channelSelect_ff, expLines, pulsed, lines;
	logic [7:0]  expectedAddr_ff;
	logic [15:0] cfgWord, cfgValue_ff;
	logic [31:0] p;
	int          fail_count, samples_checked;

	standalone_packet_output_decoder #(.PULSE_LEN(P)) uut (.*);
	remote_transmitter_model tx (.*);
	assign lines = {remote_output_4, remote_output_3, remote_output_2,
		remote_output_1};

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("Checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	task automatic doReset(input logic m);
		@(negedge clk);
		rst_n = 1'b0;
		operating_choice_pin = m;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask : doReset

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The tests need well under a thousand cycles; this bound of 20000 cycles is far above that.
	initial begin
		#200000;
		fail_count++;
		conclude();
	end

	initial begin
		{rst_n, operating_choice_pin, lowPowerStrap, cfgWrite} = 4'h6;
		{band_pick_bit1, band_pick_bit0} = 2'h0;
		{channel_pick_bit3, channel_pick_bit2} = 2'h0;
		{channel_pick_bit1, channel_pick_bit0} = 2'h0;
		cfgWord = 16'h0000;
		doReset(1'b1);
		check(standaloneMode_ff, 1'b1);
		check(modeSampled_ff, 1'b1);
		check(cfgValue_ff, CFG_DEFAULT);
		check(lowPowerEnable_ff, 1'b1);
		operating_choice_pin = 1'b0;
		for (int c = 0; c < 16; c++) begin
			{channel_pick_bit3, channel_pick_bit2, channel_pick_bit1,
				channel_pick_bit0} = c[3:0];
			{band_pick_bit1, band_pick_bit0} = c[3:2];
			lowPowerStrap = c[1];
			repeat (2) @(negedge clk);
			check(lowPowerEnable_ff, c[1]);
			check(expectedAddr_ff, ADDRS[c[1:0]]);
			check(strength_threshold_flag, c[0]);
			check(bandSelect_ff, c[3:2]);
			check(channelSelect_ff, c[3:0]);
			check(standaloneMode_ff, 1'b1);
		end
		$display("Test straps done");
		foreach (PKTS[k]) begin
			cfgWrite = 1'b1;
			cfgWord = PKTS[k][15:0];
			@(negedge clk);
			check(cfgValue_ff, PKTS[k][15:0]);
		end
		cfgWrite = 1'b0;
		check(standaloneMode_ff, 1'b1);
		$display("Test config done");
		{channel_pick_bit1, channel_pick_bit0} = 2'h0;
		expLines = 4'h0;
		foreach (PKTS[k]) begin
			p = PKTS[k];
			good = p[31:24] == ADDR_CH0 && p[15:8] == ~p[23:16]
				&& p[7:0] == p[23:16];
			pulsed = 4'h0;
			tx.sendPacket(p[31:24], p[23:16], p[15:8], p[7:0]);
			check(packetAccepted_ff, good);
			check(packetDiscarded_ff, !good && p[31:24] == ADDR_CH0);
			for (int j = 0; j < OUT_COUNT; j++) begin
				code = p[16 + FIELD_BITS * j +: 2];
				if (good && code == CODE_LOW) expLines[j] = 1'b0;
				if (good && code == CODE_TOGGLE) expLines[j] = ~expLines[j];
				if (good && code == CODE_PULSE) pulsed[j] = 1'b1;
			end
			expLines |= pulsed;
			@(negedge clk);
			check(lines, expLines);
			if (pulsed != 4'h0) begin
				repeat (P / 2) @(negedge clk);
				check(lines, expLines);
				repeat (P / 2 + 4) @(negedge clk);
				expLines &= ~pulsed;
				check(lines, expLines);
			end
		end
		$display("Test packets done");
		doReset(1'b0);
		channel_pick_bit0 = 1'b1;
		repeat (2) @(negedge clk);
		check(standaloneMode_ff, 1'b0);
		check(strength_threshold_flag, 1'b0);
		check(lowPowerEnable_ff, 1'b0);
		tx.sendPacket(8'hD4, 8'hAA, 8'h55, 8'hAA);
		repeat (2) @(negedge clk);
		check(lines, 4'h0);
		$display("Test processor mode done");
		conclude();
	end
endmodule : standalone_packet_output_decoder_bench
